// ==== verilog/eic_top.sv ====
// Extended interrupt configuration, pending flags and priority selection.
//
// What this block does
// - Serial enable write: 10 low, 11 high, 01 off.
// - Serial enable read: 10 low, 11 high, 00 off.
// - External 2-4 enables use the same coding.
// - External 2-4 each select level or edge.
// - Type 0 follows level, type 1 catches edges.
// - Type write: 10 level, 11 edge, 0X keep.
// - Type read: 00 level, 01 edge.
// - One pending flag per external 2-4.
// - Software can set or clear pending flags.
// - Five inputs have separate polarity fields.
// - Polarity write: 10 low, 11 high, 0X keep.
// - Inputs pass two flops before detection.
// - Pending write: 10 clear, 11 set, 0X keep.
// - Fixed order, high first, busy levels block.
// - Served vector is eight times number plus three.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module eic_top
    import eic_pkg::*;
(
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Register port.
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata_ff,
    // External request pins 0 to 4.
    input  wire logic [4:0] ext_request_pin,
    // Core state and serial-port requests.
    input  wire logic [3:0] serial_irq_req,
    input  wire logic       global_irq_en,
    input  wire logic       high_in_progress,
    input  wire logic       low_in_progress,
    // Detected activity on external inputs 0 and 1.
    output logic [1:0]      ext01_level_ff,
    output logic [1:0]      ext01_edge_ff,
    // Selected interrupt and summary interrupt.
    output eic_serve_t      serve_ff,
    output logic            irq_ff
);

    logic [3:0] ser_en;
    logic [3:0] ser_hi;
    logic [2:0] ext_en;
    logic [2:0] ext_hi;
    logic [2:0] trig_q;
    logic [4:0] pol_q;
    logic [4:0] act_lvl;
    logic [4:0] act_edge;
    logic [2:0] pend_ff;
    logic [2:0] nxt_pend;
    logic [2:0] hw_set;
    logic [2:0] stat_ff;
    logic [2:0] nxt_stat;
    logic [2:0] mask_ff;
    logic [2:0] nxt_mask;
    logic [7:0] nxt_rdata;
    logic       nxt_irq;
    logic [1:0] nxt_lvl01;
    logic [1:0] nxt_edge01;
    eic_serve_t nxt_serve;
    logic       wr_ser;
    logic       wr_ext;
    logic       wr_trig;
    logic       wr_pol;
    logic       wr_pend;

    // Write decode.
    assign wr_ser  = reg_wr && (reg_addr == EIC_OFS_SER_EN);
    assign wr_ext  = reg_wr && (reg_addr == EIC_OFS_EXT_EN);
    assign wr_trig = reg_wr && (reg_addr == EIC_OFS_TRIG);
    assign wr_pol  = reg_wr && (reg_addr == EIC_OFS_POL);
    assign wr_pend = reg_wr && (reg_addr == EIC_OFS_PEND);

    // Serial enables: serial 1 sits in the top field.
    for (genvar k = 0; k < 4; k++) begin : g_ser
        eic_cmd_field #(.HAS_OFF(1'b1), .RST_VAL(1'b0)) u_fld (
            .clock   (clock),
            .sys_rst (sys_rst),
            .wr_en   (wr_ser),
            .cmd     (reg_wdata[EIC_FLD_W*(3-k) +: EIC_FLD_W]),
            .en_ff   (ser_en[k]),
            .val_ff  (ser_hi[k])
        );
    end

    // External 2 to 4 enables: external 2 sits in the bottom field.
    for (genvar j = 0; j < 3; j++) begin : g_ext
        eic_cmd_field #(.HAS_OFF(1'b1), .RST_VAL(1'b0)) u_fld (
            .clock   (clock),
            .sys_rst (sys_rst),
            .wr_en   (wr_ext),
            .cmd     (reg_wdata[EIC_FLD_W*j +: EIC_FLD_W]),
            .en_ff   (ext_en[j]),
            .val_ff  (ext_hi[j])
        );
        // Per-input trigger type, level after reset.
        eic_cmd_field #(.HAS_OFF(1'b0), .RST_VAL(EIC_TRIG_RST)) u_trig (
            .clock   (clock),
            .sys_rst (sys_rst),
            .wr_en   (wr_trig),
            .cmd     (reg_wdata[EIC_FLD_W*(EIC_IT_FLD0+j) +: EIC_FLD_W]),
            .en_ff   (),
            .val_ff  (trig_q[j])
        );
    end

    // Polarity of all five inputs; input 0 lives beside the trigger types.
    for (genvar i = 0; i < 5; i++) begin : g_pol
        logic       pol_wr;
        logic [1:0] pol_cmd;
        if (i == 0) begin : g_al0
            assign pol_wr  = wr_trig;
            assign pol_cmd = reg_wdata[EIC_FLD_W*EIC_AL0_FLD +: EIC_FLD_W];
        end else begin : g_aln
            assign pol_wr  = wr_pol;
            assign pol_cmd = reg_wdata[EIC_FLD_W*(i-1) +: EIC_FLD_W];
        end
        eic_cmd_field #(.HAS_OFF(1'b0), .RST_VAL(EIC_POL_RST)) u_fld (
            .clock   (clock),
            .sys_rst (sys_rst),
            .wr_en   (pol_wr),
            .cmd     (pol_cmd),
            .en_ff   (),
            .val_ff  (pol_q[i])
        );
        eic_pin_detect u_pin (
            .clock    (clock),
            .sys_rst  (sys_rst),
            .pin_raw  (ext_request_pin[i]),
            .pol_high (pol_q[i]),
            .act_lvl  (act_lvl[i]),
            .act_edge (act_edge[i])
        );
    end

    // Pending flags: hardware set wins over a software clear.
    always_comb begin
        for (int j = 0; j < 3; j++) begin
            hw_set[j]   = trig_q[j] ? act_edge[j+2] : act_lvl[j+2];
            nxt_pend[j] = pend_ff[j];
            if (wr_pend && reg_wdata[2*j+1]) begin
                nxt_pend[j] = reg_wdata[2*j];
            end
            if (hw_set[j]) begin
                nxt_pend[j] = 1'b1;
            end
        end
    end

    // Register the pending flags.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pend_ff <= '0;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    // Sticky status of new pending events, write one to clear, and mask.
    always_comb begin
        nxt_stat = stat_ff;
        nxt_mask = mask_ff;
        if (reg_wr && (reg_addr == EIC_OFS_ISTAT)) begin
            nxt_stat = stat_ff & ~reg_wdata[2:0];
        end
        if (reg_wr && (reg_addr == EIC_OFS_IMASK)) begin
            nxt_mask = reg_wdata[2:0];
        end
        nxt_stat = nxt_stat | (hw_set & ~pend_ff);
        nxt_irq  = |(stat_ff & mask_ff);
    end

    // Register status, mask and the interrupt line.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stat_ff <= '0;
            mask_ff <= '0;
            irq_ff  <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            irq_ff  <= nxt_irq;
        end
    end

    // Read mux; disabled fields and unused upper bits read as zero.
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                EIC_OFS_SER_EN: begin
                    for (int k = 0; k < 4; k++) begin
                        nxt_rdata[2*(3-k)+1] = ser_en[k];
                        nxt_rdata[2*(3-k)]   = ser_en[k] & ser_hi[k];
                    end
                end
                EIC_OFS_EXT_EN: begin
                    for (int j = 0; j < 3; j++) begin
                        nxt_rdata[2*j+1] = ext_en[j];
                        nxt_rdata[2*j]   = ext_en[j] & ext_hi[j];
                    end
                end
                EIC_OFS_TRIG: begin
                    nxt_rdata[0] = pol_q[0];
                    for (int j = 0; j < 3; j++) begin
                        nxt_rdata[2*(j+1)] = trig_q[j];
                    end
                end
                EIC_OFS_POL: begin
                    for (int i = 1; i < 5; i++) begin
                        nxt_rdata[2*(i-1)] = pol_q[i];
                    end
                end
                EIC_OFS_PEND: begin
                    for (int j = 0; j < 3; j++) begin
                        nxt_rdata[2*j] = pend_ff[j];
                    end
                end
                EIC_OFS_ISTAT: nxt_rdata = {5'h00, stat_ff};
                EIC_OFS_IMASK: nxt_rdata = {5'h00, mask_ff};
                default:       nxt_rdata = 8'h00;
            endcase
        end
    end

    // Priority selection among the seven sources, lowest number first.
    always_comb begin
        logic [6:0] req;
        logic [6:0] en;
        logic [6:0] hi;
        logic       hi_hit;
        logic       lo_hit;
        logic [2:0] hi_idx;
        logic [2:0] lo_idx;
        logic [3:0] num;
        req = {pend_ff[2], serial_irq_req[3], pend_ff[1], serial_irq_req[2],
               pend_ff[0], serial_irq_req[1], serial_irq_req[0]};
        en  = {ext_en[2], ser_en[3], ext_en[1], ser_en[2],
               ext_en[0], ser_en[1], ser_en[0]};
        hi  = {ext_hi[2], ser_hi[3], ext_hi[1], ser_hi[2],
               ext_hi[0], ser_hi[1], ser_hi[0]};
        hi_hit = 1'b0;
        lo_hit = 1'b0;
        hi_idx = 3'h0;
        lo_idx = 3'h0;
        num    = 4'h0;
        for (int k = EIC_NSRC - 1; k >= 0; k--) begin
            if (req[k] && en[k] && hi[k]) begin
                hi_hit = 1'b1;
                hi_idx = 3'(k);
            end
            if (req[k] && en[k] && !hi[k]) begin
                lo_hit = 1'b1;
                lo_idx = 3'(k);
            end
        end
        nxt_serve = '0;
        if (global_irq_en && !high_in_progress) begin
            if (hi_hit) begin
                nxt_serve.valid = 1'b1;
                nxt_serve.high  = 1'b1;
                num = EIC_SRC_NUMS[4*hi_idx +: 4];
            end else if (lo_hit && !low_in_progress) begin
                nxt_serve.valid = 1'b1;
                num = EIC_SRC_NUMS[4*lo_idx +: 4];
            end
        end
        if (nxt_serve.valid) begin
            nxt_serve.num = num;
            nxt_serve.vec = {1'b0, num, 3'h0} + EIC_VEC_OFS;
        end
        nxt_lvl01  = act_lvl[1:0];
        nxt_edge01 = act_edge[1:0];
    end

    // Register read data, selection and external 0/1 activity.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata_ff   <= 8'h00;
            serve_ff       <= '0;
            ext01_level_ff <= 2'h0;
            ext01_edge_ff  <= 2'h0;
        end else begin
            reg_rdata_ff   <= nxt_rdata;
            serve_ff       <= nxt_serve;
            ext01_level_ff <= nxt_lvl01;
            ext01_edge_ff  <= nxt_edge01;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Command and read-back sequences.
    sequence s_ser1_off;
        reg_wr && reg_addr == EIC_OFS_SER_EN && reg_wdata[7:6] == 2'h1;
    endsequence
    sequence s_rd_ser;
        reg_rd && reg_addr == EIC_OFS_SER_EN;
    endsequence
    sequence s_it2_edge;
        wr_trig && reg_wdata[3:2] == 2'h3;
    endsequence

    property p_ser_high;
        wr_ser && reg_wdata[7:6] == 2'h3 |=> ser_en[0] && ser_hi[0];
    endproperty
    a_ser_high: assert property (p_ser_high)
        else $error("Serial 1 not enabled high after command 11.");

    property p_ser_off_read;
        s_ser1_off ##1 s_rd_ser |=> reg_rdata_ff[7] == 1'b0;
    endproperty
    a_ser_off_read: assert property (p_ser_off_read)
        else $error("Disabled serial 1 reads with upper bit set.");

    property p_ext_keep;
        wr_ext && reg_wdata[1:0] == 2'h0 |=> $stable(ext_en[0])
            && $stable(ext_hi[0]);
    endproperty
    a_ext_keep: assert property (p_ext_keep)
        else $error("External 2 enable changed on command 00.");

    property p_trig_read;
        s_it2_edge ##1 (reg_rd && reg_addr == EIC_OFS_TRIG)
            |=> reg_rdata_ff[3:2] == 2'h1;
    endproperty
    a_trig_read: assert property (p_trig_read)
        else $error("Edge type of external 2 does not read 01.");

    property p_edge_sets;
        trig_q[1] && act_edge[3] |=> pend_ff[1]
            ##1 (pend_ff[1] || $past(wr_pend && reg_wdata[3:2] == 2'h2));
    endproperty
    a_edge_sets: assert property (p_edge_sets)
        else $error("Edge did not set external 3 flag or it dropped.");

    property p_level_sets;
        !trig_q[1] && act_lvl[3] |=> pend_ff[1];
    endproperty
    a_level_sets: assert property (p_level_sets)
        else $error("Active level did not raise external 3 flag.");

    property p_sw_clear;
        wr_pend && reg_wdata[5:4] == 2'h2 && !hw_set[2] |=> !pend_ff[2];
    endproperty
    a_sw_clear: assert property (p_sw_clear)
        else $error("Command 10 did not clear external 4 flag.");

    property p_sync_lvl;
        ($stable(pol_q[2]) && ext_request_pin[2])[*3]
            |-> act_lvl[2] == pol_q[2];
    endproperty
    a_sync_lvl: assert property (p_sync_lvl)
        else $error("Synchronised level of input 2 is wrong.");

    property p_no_serve_busy;
        serve_ff.valid |-> $past(global_irq_en) && !$past(high_in_progress);
    endproperty
    a_no_serve_busy: assert property (p_no_serve_busy)
        else $error("Interrupt served while blocked.");

    property p_vector;
        serve_ff.valid |-> serve_ff.vec == {1'b0, serve_ff.num, 3'h0} + 8'h03;
    endproperty
    a_vector: assert property (p_vector)
        else $error("Served vector is not eight times number plus three.");

    property p_after_reset;
        $past(sys_rst) |-> pend_ff == 3'h0 && ser_en == 4'h0
            && ext_en == 3'h0;
    endproperty
    a_after_reset: assert property (p_after_reset)
        else $error("Flags or enables not clear after reset.");

endmodule
`default_nettype wire

// ==== verilog/eic_pkg.sv ====
// Package with the register map, field codes and carrier types of the unit.
package eic_pkg;

    // Register offsets on the special function register port.
    localparam logic [7:0] EIC_OFS_SER_EN  = 8'had;
    localparam logic [7:0] EIC_OFS_EXT_EN  = 8'hae;
    localparam logic [7:0] EIC_OFS_TRIG    = 8'hba;
    localparam logic [7:0] EIC_OFS_POL     = 8'hbb;
    localparam logic [7:0] EIC_OFS_PEND    = 8'hbc;
    localparam logic [7:0] EIC_OFS_ISTAT   = 8'hc0;
    localparam logic [7:0] EIC_OFS_IMASK   = 8'hc1;

    // Two-bit write command codes shared by all fields.
    localparam logic [1:0] EIC_CMD_LOW     = 2'h2;
    localparam logic [1:0] EIC_CMD_HIGH    = 2'h3;
    localparam logic [1:0] EIC_CMD_OFF     = 2'h1;

    // Field layout: field i occupies bits [2*i+1:2*i].
    localparam int         EIC_FLD_W       = 2;
    localparam int         EIC_AL0_FLD     = 0;
    localparam int         EIC_IT_FLD0     = 1;

    // Reset values of the configuration bits.
    localparam logic       EIC_POL_RST     = 1'b0;
    localparam logic       EIC_TRIG_RST    = 1'b0;

    // Interrupt numbers of the seven served sources, lowest index first.
    localparam int         EIC_NSRC        = 7;
    localparam logic [27:0] EIC_SRC_NUMS   = {4'he, 4'hd, 4'hc, 4'hb,
                                              4'ha, 4'h9, 4'h7};
    localparam logic [7:0] EIC_VEC_OFS     = 8'h03;

    // Enable state of one source.
    typedef struct packed {
        logic       en;
        logic       hi;
    } eic_en_t;

    // Interrupt selected for service this cycle.
    typedef struct packed {
        logic       valid;
        logic       high;
        logic [3:0] num;
        logic [7:0] vec;
    } eic_serve_t;

endpackage

// ==== verilog/eic_cmd_field.sv ====
// One two-bit command field with its stored enable and value bits.
`timescale 1ns/1ps
`default_nettype none
module eic_cmd_field
    import eic_pkg::*;
#(
    parameter bit HAS_OFF = 1'b1,
    parameter bit RST_VAL = 1'b0
) (
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Write command.
    input  wire logic       wr_en,
    input  wire logic [1:0] cmd,
    // Stored state.
    output logic            en_ff,
    output logic            val_ff
);

    logic nxt_en;
    logic nxt_val;

    // Decode the command; code 00 keeps the state, and so does 01 unless HAS_OFF is set.
    always_comb begin
        nxt_en  = en_ff;
        nxt_val = val_ff;
        if (wr_en) begin
            case (cmd)
                EIC_CMD_LOW: begin
                    nxt_en  = 1'b1;
                    nxt_val = 1'b0;
                end
                EIC_CMD_HIGH: begin
                    nxt_en  = 1'b1;
                    nxt_val = 1'b1;
                end
                EIC_CMD_OFF: begin
                    if (HAS_OFF) begin
                        nxt_en = 1'b0;
                    end
                end
                default: begin
                    nxt_en  = en_ff;
                    nxt_val = val_ff;
                end
            endcase
        end
    end

    // Register the field.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            en_ff  <= 1'b0;
            val_ff <= RST_VAL;
        end else begin
            en_ff  <= nxt_en;
            val_ff <= nxt_val;
        end
    end

endmodule
`default_nettype wire

// ==== verilog/eic_pin_detect.sv ====
// Request pin synchroniser with polarity and active-going edge detection.
`timescale 1ns/1ps
`default_nettype none
module eic_pin_detect (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic sys_rst,
    // Raw pin and selected polarity, high meaning high or rising active.
    input  wire logic pin_raw,
    input  wire logic pol_high,
    // Active level and one-cycle active-going edge.
    output logic      act_lvl,
    output logic      act_edge
);

    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    logic nxt_prev;

    // The previous active level is what the edge compares against.
    always_comb begin
        act_lvl  = pol_high ? sync_ff : ~sync_ff;
        act_edge = act_lvl & ~prev_ff;
        nxt_prev = act_lvl;
    end

    // Two flops bring the pin into the clock domain before any logic.
    // They reset high, the inactive level for the low-active polarity that
    // reset selects, so an idle pin raises no level flag after release.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else begin
            meta_ff <= pin_raw;
            sync_ff <= meta_ff;
            prev_ff <= nxt_prev;
        end
    end

endmodule
`default_nettype wire

// ==== sim/eic_far_model.sv ====
// Behavioural model of the core state and the external request pins.
`timescale 1ns/1ps
`default_nettype none
module eic_far_model (
    // Request pins.
    output logic [4:0] ext_request_pin,
    // Core state and serial-port requests.
    output logic [3:0] serial_irq_req,
    output logic       global_irq_en,
    output logic       high_in_progress,
    output logic       low_in_progress
);
    // Pins idle high so that the reset polarity sees them inactive.
    initial begin
        ext_request_pin  = 5'h1f;
        serial_irq_req   = 4'h0;
        global_irq_en    = 1'b0;
        high_in_progress = 1'b0;
        low_in_progress  = 1'b0;
    end
    // Pins change right after a rising edge.
    task automatic pins(input logic [4:0] v);
        ext_request_pin <= v;
    endtask
    // Core state changes right after a rising edge.
    task automatic core(input logic [6:0] v);
        {global_irq_en, high_in_progress, low_in_progress,
         serial_irq_req} <= v;
    endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the extended interrupt configuration unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import eic_pkg::*;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  rdat;
    logic [4:0]  pin;
    logic [3:0]  sreq;
    logic        ge, hip, lip, irq;
    logic [1:0]  lvl, edg;
    eic_serve_t  serve;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cnt;
    logic [31:0] seed = 32'hf5d3;
    logic [13:0] es;
    logic [7:0]  rv, a;
    logic [7:0]  m_ser = 0, m_ext = 0, m_trig = 0, m_pol = 0, m_pend = 0;
    localparam logic [63:0] ALL = {8'h55, EIC_OFS_IMASK, EIC_OFS_ISTAT,
        EIC_OFS_PEND, EIC_OFS_POL, EIC_OFS_TRIG, EIC_OFS_EXT_EN,
        EIC_OFS_SER_EN};

    // Clock at 40 MHz.
    always #12.5 clock = ~clock;

    // Device and far side.
    eic_top dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(rdat), .ext_request_pin(pin), .serial_irq_req(sreq),
        .global_irq_en(ge), .high_in_progress(hip), .low_in_progress(lip),
        .ext01_level_ff(lvl), .ext01_edge_ff(edg), .serve_ff(serve),
        .irq_ff(irq));
    eic_far_model far (.ext_request_pin(pin), .serial_irq_req(sreq),
        .global_irq_en(ge), .high_in_progress(hip), .low_in_progress(lip));

    // Next random word.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Applies a write to the read image of a command-field register.
    function automatic logic [7:0] upd(input logic [7:0] cur,
        input logic [7:0] wd, input bit en, input int nf);
        logic [1:0] c;
        upd = cur;
        for (int i = 0; i < nf; i++) begin
            c = wd[2*i +: 2];
            if (en && c != 2'h0)
                upd[2*i +: 2] = (c == 2'h1) ? 2'h0 : c;
            else if (!en && c[1])
                upd[2*i +: 2] = {1'b0, c[0]};
        end
    endfunction

    // Expected read value of a register.
    function automatic logic [7:0] img(input logic [7:0] ad);
        case (ad)
            EIC_OFS_SER_EN: return m_ser;
            EIC_OFS_EXT_EN: return m_ext;
            EIC_OFS_TRIG:   return m_trig;
            EIC_OFS_POL:    return m_pol;
            default:        return 8'h00;
        endcase
    endfunction

    // Expected selection: fixed order, high pass before low pass.
    function automatic logic [13:0] exp_serve();
        logic [13:0] f;
        logic [6:0]  fl;
        int          n;
        f = {m_ext[5:4], m_ser[1:0], m_ext[3:2], m_ser[3:2], m_ext[1:0],
             m_ser[5:4], m_ser[7:6]};
        fl = {m_pend[4], sreq[3], m_pend[2], sreq[2], m_pend[0], sreq[1:0]};
        exp_serve = 14'h0;
        for (int p = 1; p >= 0; p--)
            for (int s = 0; s < 7; s++) begin
                n = (s == 0) ? 7 : s + 8;
                if (exp_serve == 0 && ge && !hip && !(p == 0 && lip) &&
                    f[2*s +: 2] == {1'b1, p[0]} && fl[s])
                    exp_serve = {1'b1, p[0], n[3:0], 8'(n * 8 + 3)};
            end
    endfunction

    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle register write, model updated alongside.
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        case (ad)
            EIC_OFS_SER_EN: m_ser = upd(m_ser, d, 1, 4);
            EIC_OFS_EXT_EN: m_ext = upd(m_ext, d, 1, 3);
            EIC_OFS_TRIG:   m_trig = upd(m_trig, d, 0, 4);
            EIC_OFS_POL:    m_pol = upd(m_pol, d, 0, 4);
            EIC_OFS_PEND:   m_pend = upd(m_pend, d, 0, 3);
            default: ;
        endcase
    endtask

    // One-cycle read, data taken in the following cycle and compared.
    task automatic rc(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(rdat, e);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        results();
    end

    // Main sequence.
    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++)
            rc(ALL[8*i +: 8], 8'h00);
        for (int i = 0; i < 60; i++) begin
            seed = lfsr(seed);
            a = ALL[8*seed[9:8] +: 8];
            wr(a, seed[7:0]);
            rc(a, img(a));
        end
        wr(8'h55, seed[15:8]);
        rc(8'h55, 8'h00);
        wr(EIC_OFS_POL, 8'hfe);
        wr(EIC_OFS_TRIG, 8'hab);
        far.pins(5'h00);
        repeat (5) @(posedge clock);
        wr(EIC_OFS_PEND, 8'h2a);
        wr(EIC_OFS_ISTAT, 8'h07);
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            wr(EIC_OFS_PEND, seed[7:0]);
            rc(EIC_OFS_PEND, m_pend);
        end
        wr(EIC_OFS_PEND, 8'h2a);
        @(posedge clock);
        far.pins(5'h04);
        @(posedge clock);
        rc(EIC_OFS_PEND, 8'h00);
        m_pend = 8'h01;
        rc(EIC_OFS_PEND, m_pend);
        wr(EIC_OFS_PEND, 8'h02);
        m_pend = 8'h01;
        rc(EIC_OFS_PEND, m_pend);
        rc(EIC_OFS_ISTAT, 8'h01);
        wr(EIC_OFS_IMASK, 8'h01);
        repeat (2) @(posedge clock);
        #1 chk(irq, 1'b1);
        wr(EIC_OFS_IMASK, 8'h00);
        repeat (2) @(posedge clock);
        #1 chk(irq, 1'b0);
        // Input 2 released; input 0 high-active rises, input 1 low-active.
        far.pins(5'h01);
        cnt = 0;
        repeat (6) begin
            @(posedge clock);
            #1 if (edg[0] === 1'b1) cnt++;
        end
        chk(cnt, 1);
        chk(lvl, 2'b11);
        wr(EIC_OFS_PEND, 8'h02);
        wr(EIC_OFS_ISTAT, 8'h01);
        rc(EIC_OFS_ISTAT, 8'h00);
        wr(EIC_OFS_IMASK, 8'h01);
        repeat (2) @(posedge clock);
        #1 chk(irq, 1'b0);
        // Rising edges on inputs 3 and 4, both in edge mode.
        wr(EIC_OFS_TRIG, 8'hf0);
        rc(EIC_OFS_TRIG, m_trig);
        far.pins(5'h19);
        repeat (6) @(posedge clock);
        m_pend = 8'h14;
        rc(EIC_OFS_PEND, m_pend);
        rc(EIC_OFS_ISTAT, 8'h06);
        wr(EIC_OFS_PEND, 8'h28);
        rc(EIC_OFS_PEND, 8'h00);
        // Falling edge on input 4 after switching it to low-active.
        wr(EIC_OFS_POL, 8'h80);
        wr(EIC_OFS_PEND, 8'h20);
        rc(EIC_OFS_PEND, 8'h00);
        far.pins(5'h01);
        repeat (4) @(posedge clock);
        m_pend = 8'h10;
        rc(EIC_OFS_PEND, m_pend);
        wr(EIC_OFS_PEND, 8'h20);
        // Random enables, flags and core state against the selection model.
        for (int i = 0; i < 80; i++) begin
            seed = lfsr(seed);
            wr(EIC_OFS_SER_EN, seed[7:0]);
            wr(EIC_OFS_EXT_EN, seed[15:8]);
            wr(EIC_OFS_PEND, seed[23:16]);
            far.core({seed[30] | seed[29], seed[29] & seed[28],
                      seed[27] & seed[26], seed[27:24]});
            repeat (3) @(posedge clock);
            #1 es = exp_serve();
            if (es[13])
                chk(serve, es);
            else
                chk(serve.valid, 1'b0);
            rc(EIC_OFS_EXT_EN, m_ext);
        end
        results();
    end
endmodule
`default_nettype wire
